// File: logic/cmp_ref_pkg.sv
package cmp_ref_pkg;
    // register word offsets on the wishbone bus (byte addresses)
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_CTRL3 = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_REFCTL = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam int NUM_CMP = 3;
    // comparator control field positions
    localparam int CC_ENABLE = 15;
    localparam int CC_PIN_OE = 14;
    localparam int CC_INVERT = 13;
    localparam int CC_EVENT = 9;
    localparam int CC_RESULT = 8;
    localparam int CC_EVPOL_HI = 7;
    localparam int CC_EVPOL_LO = 6;
    localparam int CC_NONINV = 4;
    localparam int CC_CH_HI = 1;
    localparam int CC_CH_LO = 0;
    // status register field positions
    localparam int ST_IDLE_STOP = 15;
    localparam int ST_EVT_LO = 8;
    localparam int ST_OUT_LO = 0;
    // write masks: writable bits of the control and reference control registers
    localparam logic [15:0] CTRL_WMASK = 16'hE2D3;
    localparam logic [15:0] REF_WMASK = 16'h07FF;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    // input channel and reference source codes
    localparam logic [1:0] CH_PIN_B = 2'b00;
    localparam logic [1:0] CH_PIN_C = 2'b01;
    localparam logic [1:0] CH_PIN_D = 2'b10;
    localparam logic [1:0] CH_INT_REF = 2'b11;
    localparam logic [1:0] SRC_BANDGAP = 2'b00;
    localparam logic [1:0] SRC_EXT_POS = 2'b11;
    // event polarity codes
    localparam logic [1:0] EVP_OFF = 2'b00;
    localparam logic [1:0] EVP_RISE = 2'b01;
    localparam logic [1:0] EVP_FALL = 2'b10;
    localparam logic [1:0] EVP_ANY = 2'b11;

    // reference control fields
    typedef struct packed {
        logic [4:0] unused;
        logic external_ref_select;
        logic [1:0] inv_ref_source;
        logic ref_power_enable;
        logic ref_pin_output_enable;
        logic ref_supply_select;
        logic [4:0] ref_level_code;
    } ref_ctrl_t;

    // per-comparator analog steering
    typedef struct packed {
        logic enable;
        logic noninv_internal;
        logic noninv_ext_pos;
        logic [1:0] inv_input_channel;
        logic inv_ref_bandgap;
        logic inv_ref_ext_pos;
    } cmp_route_t;
endpackage

// File: logic/comparator_reference_control_regs.sv
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// R1: control bit 4 set routes internal reference to non-inverting input, else pin A.
// R2: control bits 1-0 pick inverting input: 11 ref, 10 D, 01 C, 00 B.
// R3: status bit 15 set stops all comparators during idle mode.
// R4: status bits 10-8 mirror event flags of comparators 3-1, read only.
// R5: status bits 2-0 mirror output bits of comparators 3-1, read only.
// R6: unimplemented bits of status, control and reference control read zero.
// R7: reference bit 10 picks external positive reference over ladder when non-inverting set.
// R8: reference bits 9-8 pick band gap (00) or external positive (11) for channel 11.
// R9: reference bit 7 powers the reference circuit on.
// R10: reference bit 6 drives the reference level onto its pin.
// R11: reference bit 5 picks external pair as ladder source, else analog rails.
// R12: reference bits 4-0 hold ladder code 0 to 31, level is code over 32.
// R13: hardware sets event flag on selected event; set flag suppresses further triggers.
// R14: control bit 13 inverts the comparator output bit.
// R15: status mirrors follow control event and output bits combinationally.
// R16: status and reference control writable fields reset to zero.
module comparator_reference_control_regs
    import cmp_ref_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    // analog side: raw comparator results, device idle state
    input wire logic [NUM_CMP-1:0] raw_compare_in,
    input wire logic idle_mode_in,
    // analog steering controls
    output cmp_route_t [NUM_CMP-1:0] route_out,
    output logic [NUM_CMP-1:0] pin_drive_out,
    output logic [NUM_CMP-1:0] compare_result_out,
    output logic [NUM_CMP-1:0] trigger_out,
    output logic ref_power_enable_out,
    output logic ref_pin_output_enable_out,
    output logic ref_supply_select_out,
    output logic [4:0] ref_level_code_out,
    // interrupt
    output logic irq_out
);
    typedef logic [15:0] word_t;

    // register map, byte offsets on the bus, data in bits 15:0:
    //   0x00, 0x04, 0x08  comparator_control of comparators 1 to 3
    //   0x0c              comparator_module_status
    //   0x10              reference_voltage_control
    //   0x14              interrupt status, write one to clear
    //   0x18              interrupt mask
    // any other offset is answered with err and changes nothing
    // sel lanes 2 and 3 are ignored, since no register is wider than 16 bits
    // every access is answered one cycle after it is taken; a request
    // still held while ack or err stands is not taken a second time

    // the register map only leaves control offsets for three comparators
    if (NUM_CMP < 1 || NUM_CMP > 3) begin : g_bad_count
        $error("comparator count not supported");
    end

    // register state
    word_t ctrl [NUM_CMP];
    word_t next_ctrl [NUM_CMP];
    logic all_stop_in_idle;
    logic next_all_stop_in_idle;
    ref_ctrl_t ref_ctrl;
    ref_ctrl_t next_ref_ctrl;
    logic [NUM_CMP-1:0] irq_stat;
    logic [NUM_CMP-1:0] next_irq_stat;
    logic [NUM_CMP-1:0] irq_mask;
    logic [NUM_CMP-1:0] next_irq_mask;
    // two-stage synchroniser for the analog results
    logic [NUM_CMP-1:0] sync1;
    logic [NUM_CMP-1:0] sync2;
    // edge detector history and per-cycle event terms
    logic [NUM_CMP-1:0] prev_result;
    logic [NUM_CMP-1:0] next_prev_result;
    logic [NUM_CMP-1:0] result;
    logic [NUM_CMP-1:0] event_hit;
    logic [NUM_CMP-1:0] running;
    // bus side
    logic [31:0] next_rdata;
    logic next_ack;
    logic next_err;
    logic req;
    logic wr;
    logic hit;
    // assembled words and lane masks
    word_t status_word;
    word_t wdata;
    word_t wbe;

    // byte enables to a 16-bit lane mask
    function automatic word_t lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // merge a write, touching only writable bits of enabled lanes
    function automatic word_t merge_write(input word_t cur, input word_t wd,
                                          input word_t wmask, input word_t lanes);
        merge_write = (cur & ~(wmask & lanes)) | (wd & wmask & lanes);
    endfunction

    // true when a taken write targets the given register offset
    function automatic logic write_at(input logic take, input logic [7:0] adr,
                                      input logic [7:0] ofs);
        write_at = take && (adr == ofs);
    endfunction

    // event detector on the polarity-corrected output
    // code 00 never fires, so a disabled event leaves the flag alone
    function automatic logic edge_event(input logic [1:0] pol, input logic now,
                                        input logic was);
        unique case (pol)
            EVP_OFF: edge_event = 1'b0;
            EVP_RISE: edge_event = now & ~was;
            EVP_FALL: edge_event = ~now & was;
            EVP_ANY: edge_event = now ^ was;
        endcase
    endfunction

    // analog results come from outside the clock domain
    // only the second stage is read; the first may still be metastable,
    // which costs two cycles of latency on every result
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw_compare_in;
            sync2 <= sync1;
        end
    end

    // a request is taken once; the registered answer masks it in its own cycle
    // only the low 16 bits of the data bus carry register contents
    assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
    assign wr = req & wb_we_in;
    assign wdata = wb_dat_in[15:0];
    assign wbe = lane_mask(wb_sel_in);

    // status word assembled from live control bits
    // mirrors are wired, not copied, so both registers always read alike
    // and a read of either can never see a stale event flag
    always_comb begin
        status_word = '0; // R6
        status_word[ST_IDLE_STOP] = all_stop_in_idle;
        for (int i = 0; i < NUM_CMP; i++) begin
            status_word[ST_EVT_LO + i] = ctrl[i][CC_EVENT]; // R4 R15
            status_word[ST_OUT_LO + i] = ctrl[i][CC_RESULT]; // R5 R15
        end
    end

    // comparator state: result, event flags, interrupt status
    // the result bit is rebuilt every cycle from the synchronised pin, so a
    // software write to it is lost; an idle stop or a disable forces it low
    always_comb begin
        next_all_stop_in_idle = all_stop_in_idle;
        next_ref_ctrl = ref_ctrl;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_prev_result = prev_result;
        for (int i = 0; i < NUM_CMP; i++) begin
            // idle stop only acts while the device really sits in idle
            running[i] = ctrl[i][CC_ENABLE] & ~(idle_mode_in & all_stop_in_idle); // R3
            // polarity applied before edge detection, so rising means the read bit rises
            result[i] = running[i] & (sync2[i] ^ ctrl[i][CC_INVERT]); // R14
            // a standing event flag blocks further triggers until software clears it
            event_hit[i] = running[i] & ~ctrl[i][CC_EVENT]
                & edge_event(ctrl[i][CC_EVPOL_HI:CC_EVPOL_LO], result[i], prev_result[i]); // R13
            next_prev_result[i] = result[i];
            next_ctrl[i] = ctrl[i];
            // unimplemented and hardware-owned bits are outside the write mask
            if (write_at(wr, wb_adr_in, OFS_CTRL1 + 8'(4 * i))) begin
                next_ctrl[i] = merge_write(ctrl[i], wdata, CTRL_WMASK, wbe); // R6
            end
            next_ctrl[i][CC_RESULT] = result[i];
            // hardware set wins over a software clear in the same cycle
            if (event_hit[i]) begin
                next_ctrl[i][CC_EVENT] = 1'b1; // R13
            end
        end
        // only the idle-stop bit of the status word is writable; mirrors ignore writes
        if (write_at(wr, wb_adr_in, OFS_STATUS) && wbe[ST_IDLE_STOP]) begin
            next_all_stop_in_idle = wdata[ST_IDLE_STOP]; // R3 R4
        end
        // the upper unimplemented bits stay zero through the mask
        if (write_at(wr, wb_adr_in, OFS_REFCTL)) begin
            next_ref_ctrl = merge_write(ref_ctrl, wdata, REF_WMASK, wbe); // R6
        end
        // mask and status live in byte lane 0 only
        if (write_at(wr, wb_adr_in, OFS_IRQ_MASK) && wb_sel_in[0]) begin
            next_irq_mask = wdata[NUM_CMP-1:0];
        end
        if (write_at(wr, wb_adr_in, OFS_IRQ_STAT) && wb_sel_in[0]) begin
            next_irq_stat = irq_stat & ~wdata[NUM_CMP-1:0];
        end
        // a new event is set after the clear, so software cannot wipe a fresh one
        next_irq_stat = next_irq_stat | event_hit;
    end

    // register stage for all control state; reset leaves every comparator
    // disabled and the reference ladder powered down
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl[i] <= RESET_VAL;
            end
            all_stop_in_idle <= 1'b0; // R16
            ref_ctrl <= RESET_VAL; // R16
            irq_stat <= '0;
            irq_mask <= '0;
            prev_result <= '0;
        end else begin
            ctrl <= next_ctrl;
            all_stop_in_idle <= next_all_stop_in_idle;
            ref_ctrl <= next_ref_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prev_result <= next_prev_result;
        end
    end

    // bus decode and read mux; one wait-free ack cycle per request
    // read data is registered every cycle and only meaningful while ack stands;
    // unmapped offsets answer with err so a stray access is visible to software
    // rather than silently reading zero
    always_comb begin
        hit = 1'b1;
        next_rdata = '0;
        unique case (wb_adr_in)
            OFS_CTRL1: next_rdata[15:0] = ctrl[0];
            OFS_CTRL2: next_rdata[15:0] = ctrl[1];
            OFS_CTRL3: next_rdata[15:0] = ctrl[2];
            OFS_STATUS: next_rdata[15:0] = status_word;
            OFS_REFCTL: next_rdata[15:0] = ref_ctrl;
            OFS_IRQ_STAT: next_rdata[NUM_CMP-1:0] = irq_stat;
            OFS_IRQ_MASK: next_rdata[NUM_CMP-1:0] = irq_mask;
            default: hit = 1'b0;
        endcase
        next_ack = req & hit;
        next_err = req & ~hit;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wb_dat_out <= '0;
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
        end else begin
            wb_dat_out <= next_rdata;
            wb_ack_out <= next_ack;
            wb_err_out <= next_err;
        end
    end

    // analog steering outputs
    // these follow the registers combinationally: the analog muxes have their own
    // settling time, and a registered copy would only add a cycle of skew
    // the band gap and external paths of the inverting input only count when
    // the channel field selects the internal reference
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            route_out[i].enable = running[i];
            route_out[i].noninv_internal = ctrl[i][CC_NONINV]; // R1
            route_out[i].noninv_ext_pos = ctrl[i][CC_NONINV]
                & ref_ctrl.external_ref_select; // R7
            route_out[i].inv_input_channel = ctrl[i][CC_CH_HI:CC_CH_LO]; // R2
            route_out[i].inv_ref_bandgap = (ctrl[i][CC_CH_HI:CC_CH_LO] == CH_INT_REF)
                & (ref_ctrl.inv_ref_source == SRC_BANDGAP); // R8
            route_out[i].inv_ref_ext_pos = (ctrl[i][CC_CH_HI:CC_CH_LO] == CH_INT_REF)
                & (ref_ctrl.inv_ref_source == SRC_EXT_POS); // R8
            pin_drive_out[i] = running[i] & ctrl[i][CC_PIN_OE];
            compare_result_out[i] = ctrl[i][CC_RESULT];
        end
    end

    // trigger pulses in the very cycle the event flag is set
    assign trigger_out = event_hit; // R13

    // reference ladder controls come straight from the register, so the analog
    // side sees a new level one cycle after the write is taken
    assign ref_power_enable_out = ref_ctrl.ref_power_enable; // R9
    assign ref_pin_output_enable_out = ref_ctrl.ref_pin_output_enable; // R10
    // supply and level may change while powered; settling is software's concern
    assign ref_supply_select_out = ref_ctrl.ref_supply_select; // R11
    assign ref_level_code_out = ref_ctrl.ref_level_code; // R12

    // one level interrupt; masked sources still latch their status
    assign irq_out = |(irq_stat & irq_mask);
endmodule

// File: sim/cmp_regs_monitor.sv
`timescale 1ns/100ps
module cmp_regs_monitor
    import cmp_ref_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    // analog side
    input wire cmp_route_t [NUM_CMP-1:0] route_out,
    input wire logic [NUM_CMP-1:0] compare_result_out,
    input wire logic [NUM_CMP-1:0] trigger_out,
    input wire logic ref_power_enable_out,
    input wire logic ref_pin_output_enable_out,
    input wire logic ref_supply_select_out,
    input wire logic [4:0] ref_level_code_out
);
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // a request the slave will take at this edge
    logic req;
    logic wr0;
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    assign wr0 = req && wb_we_in && wb_sel_in[0];

    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    a_bus_answer: assert property (req |=> wb_ack_out ^ wb_err_out) else $error("no answer");
    a_err_unmapped: assert property (req && wb_adr_in > OFS_IRQ_MASK |=> wb_err_out)
        else $error("unmapped not refused");
    a_level_write: assert property (wr0 && wb_adr_in == OFS_REFCTL |=>
        ref_level_code_out == $past(wb_dat_in[4:0])) else $error("level not written");
    a_ref_ctrl_bits: assert property (wr0 && wb_adr_in == OFS_REFCTL |=>
        {ref_power_enable_out, ref_pin_output_enable_out, ref_supply_select_out}
        == $past(wb_dat_in[7:5])) else $error("ref control bits wrong");
    a_channel_route: assert property (wr0 && wb_adr_in == OFS_CTRL1 |=>
        route_out[0].inv_input_channel == $past(wb_dat_in[1:0])) else $error("channel wrong");
    a_noninv_route: assert property (wr0 && wb_adr_in == OFS_CTRL1 |=>
        (route_out[0].noninv_internal || route_out[0].noninv_ext_pos) == $past(wb_dat_in[4]))
        else $error("noninv route wrong");
    a_status_read: assert property (req && !wb_we_in && wb_adr_in == OFS_STATUS |=>
        (wb_dat_out[15:0] & 16'h78F8) == 16'h0000 && wb_dat_out[31:16] == 16'h0000
        && wb_dat_out[2:0] == $past(compare_result_out))
        else $error("status read wrong");
    a_trigger_pulse: assert property (trigger_out[0] |=> !trigger_out[0])
        else $error("trigger repeated");
endmodule

bind comparator_reference_control_regs cmp_regs_monitor i_monitor (.clk_in, .arst_n_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .wb_err_out, .route_out, .compare_result_out, .trigger_out,
    .ref_power_enable_out, .ref_pin_output_enable_out, .ref_supply_select_out,
    .ref_level_code_out);

// File: sim/comparator_reference_control_regs_tb_top.sv
`timescale 1ns/100ps
module comparator_reference_control_regs_tb_top;
    import cmp_ref_pkg::*;
    logic clk_in, arst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, idle_mode_in, rerr;
    logic [7:0] wb_adr_in;
    logic [3:0] wb_sel_in;
    logic [31:0] wb_dat_in, wb_dat_out;
    logic wb_ack_out, wb_err_out, irq_out, pwr, pin, sup;
    logic [NUM_CMP-1:0] pdrv, trg;
    logic [4:0] lvl;
    logic [NUM_CMP-1:0] raw_compare_in, compare_result_out;
    logic [15:0] rd;
    cmp_route_t [NUM_CMP-1:0] route_out;
    int bad_count, tests_run, trig_seen;

    comparator_reference_control_regs i_dut (.clk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in,
        .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
        .wb_err_out, .raw_compare_in, .idle_mode_in, .route_out, .pin_drive_out(pdrv),
        .compare_result_out, .trigger_out(trg), .ref_power_enable_out(pwr),
        .ref_pin_output_enable_out(pin), .ref_supply_select_out(sup),
        .ref_level_code_out(lvl), .irq_out);

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // count trigger pulses of comparator 1
    always @(posedge clk_in) begin
        if (trg[0] === 1'b1)
            trig_seen++;
    end

    // one classic cycle; holds the request until ack or err is seen
    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= 4'h3;
        wb_dat_in <= {16'h0000, d};
        do @(posedge clk_in); while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1);
        rd = wb_dat_out[15:0];
        rerr = wb_err_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk($sformatf("reg %h", a), exp, rd);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog: whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        complete_run();
    end

    initial begin
        {wb_cyc_in, wb_stb_in, wb_we_in, idle_mode_in, arst_n_in} = 5'h00;
        {wb_adr_in, wb_sel_in, wb_dat_in, raw_compare_in} = '0;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        // reset values and read-only or unused positions
        rdchk(OFS_STATUS, 16'h0000);
        rdchk(OFS_REFCTL, 16'h0000);
        bus(1'b1, OFS_REFCTL, 16'hFFFF);
        rdchk(OFS_REFCTL, 16'h07FF);
        bus(1'b1, OFS_REFCTL, 16'h00A5);
        chk("ref pins", 16'h00A5, {8'h00, pwr, pin, sup, lvl});
        bus(1'b1, OFS_CTRL1, 16'h7FFF);
        rdchk(OFS_CTRL1, 16'h62D3);
        bus(1'b1, OFS_STATUS, 16'hFFFF);
        rdchk(OFS_STATUS, 16'h8100);
        bus(1'b1, 8'h1C, 16'h0000);
        chk("unmapped err", 16'h0001, {15'h0000, rerr});
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, OFS_CTRL2, 16'(c));
            chk("channel", 16'(c), {14'h0000, route_out[1].inv_input_channel});
        end
        chk("bandgap route", 16'h0001, {15'h0000, route_out[1].inv_ref_bandgap});
        chk("noninv ext", 16'h0000, {15'h0000, route_out[0].noninv_ext_pos});
        bus(1'b1, OFS_REFCTL, 16'h0700);
        chk("ext routes", 16'h0006, {13'h0000, route_out[0].noninv_ext_pos,
            route_out[1].inv_ref_ext_pos, route_out[1].inv_ref_bandgap});
        bus(1'b1, OFS_STATUS, 16'h0000);
        bus(1'b1, OFS_CTRL1, 16'hC000);
        chk("pin drive", 16'h0001, {15'h0000, pdrv[0]});
        bus(1'b1, OFS_CTRL1, 16'h8000);
        $display("test registers done");
        // result, inversion and idle stop
        raw_compare_in <= 3'b001;
        repeat (5) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'h8100);
        rdchk(OFS_STATUS, 16'h0001);
        bus(1'b1, OFS_CTRL1, 16'hA000);
        repeat (5) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'hA000);
        bus(1'b1, OFS_CTRL1, 16'h8000);
        bus(1'b1, OFS_STATUS, 16'h8000);
        idle_mode_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'h8000);
        idle_mode_in <= 1'b0;
        raw_compare_in <= 3'b000;
        bus(1'b1, OFS_STATUS, 16'h0000);
        $display("test result done");
        // rising, falling and any-edge events, interrupt and suppression while flag set
        bus(1'b1, OFS_CTRL1, 16'h8040);
        bus(1'b1, OFS_IRQ_MASK, 16'h0001);
        raw_compare_in <= 3'b001;
        repeat (6) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'h8340);
        rdchk(OFS_STATUS, 16'h0101);
        chk("irq set", 16'h0001, {15'h0000, irq_out});
        bus(1'b1, OFS_IRQ_STAT, 16'h0001);
        raw_compare_in <= 3'b000;
        repeat (4) @(posedge clk_in);
        raw_compare_in <= 3'b001;
        repeat (6) @(posedge clk_in);
        chk("irq held off", 16'h0000, {15'h0000, irq_out});
        chk("triggers", 16'h0001, 16'(trig_seen));
        bus(1'b1, OFS_CTRL1, 16'h8080);
        raw_compare_in <= 3'b000;
        repeat (6) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'h8280);
        bus(1'b1, OFS_CTRL1, 16'h80C0);
        raw_compare_in <= 3'b001;
        repeat (6) @(posedge clk_in);
        rdchk(OFS_CTRL1, 16'h83C0);
        chk("triggers", 16'h0003, 16'(trig_seen));
        $display("test event done");
        // reset in mid-run returns every writable field to zero
        arst_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rdchk(OFS_REFCTL, 16'h0000);
        rdchk(OFS_STATUS, 16'h0000);
        chk("irq after reset", 16'h0000, {15'h0000, irq_out});
        $display("test reset done");
        complete_run();
    end
endmodule
